// ==== hdl/ltpc_defs.svh ====
// Purpose: shared constants of the link training port control block
// Assumes: one reference clock at 25 MHz
// Notes: words are 16 bits; marker, ctl, status, then pattern words
//
// Summary of operation
// - train only while enable high, else mission
// - restart input restarts training from any state
// - done detect when data-sending state entered
// - active output high throughout training
// - failure output on training timeout
// - frame lock per lane after training begins
// - show received preset and initialize bits
// - show received three tap update requests
// - show received three tap update status
// - 11-bit seed initialises training pattern generator
// - send preset and initialize in control block
// - send three tap requests in control block
// - send three tap status in status block
// - one-cycle pulse at received frame start
// - one-cycle pulse entering negotiation good check, only with i_an_enable high and i_an_bypass low
`ifndef LTPC_DEFS_SVH
`define LTPC_DEFS_SVH

`define LTPC_CLK_MHZ 25
`define LTPC_TIMEOUT_US 4000
`define LTPC_TIMEOUT_CYCLES (`LTPC_TIMEOUT_US * `LTPC_CLK_MHZ)
`define LTPC_FRAME_WORDS 16
`define LTPC_LOCK_FRAMES 3
`define LTPC_MARKER 16'ha5c3
`define LTPC_POS_CTL 1
`define LTPC_POS_STAT 2
`define LTPC_SEED_ZERO_FIX 11'h001

`endif

// ==== hdl/ltpc_pkg.sv ====
// Purpose: types of the link training port control block
// Assumes: constants live in ltpc_defs.svh
// Notes: field order inside the structs is the on-wire order
package ltpc_pkg;

  typedef enum logic [1:0] {
    LTPC_OFF,
    LTPC_TRAIN,
    LTPC_SEND_DATA,
    LTPC_FAIL
  } ltpc_state_t;

  typedef struct packed {
    logic preset_bit;
    logic init_bit;
    logic [1:0] post_tap_req;
    logic [1:0] main_tap_req;
    logic [1:0] pre_tap_req;
  } ltpc_ctl_t;

  typedef struct packed {
    logic [1:0] post_tap_status;
    logic [1:0] main_tap_status;
    logic [1:0] pre_tap_status;
  } ltpc_stat_t;

endpackage

// ==== hdl/ltpc_prbs.sv ====
// Purpose: 11-bit pseudo-random training pattern generator
// Assumes: polynomial x^11 + x^9 + 1, one step per enabled cycle
// Notes: an all-zero seed would freeze the register, so it is replaced
`timescale 1ns/100ps
`include "ltpc_defs.svh"
module ltpc_prbs (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [10:0] i_seed,
  input wire logic i_step,
  output logic [10:0] o_state
);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_state <= `LTPC_SEED_ZERO_FIX;
    end else if (i_load) begin
      o_state <= (i_seed == 11'h000) ? `LTPC_SEED_ZERO_FIX : i_seed;
    end else if (i_step) begin
      o_state <= {o_state[9:0], o_state[10] ^ o_state[8]};
    end
  end

  seed_load_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_load && i_seed != 11'h000) |=> (o_state == $past(i_seed)))
    else $error("pattern generator did not take the seed");

endmodule // ltpc_prbs

// ==== hdl/ltpc_top.sv ====
// Purpose: per-lane link training control and status
// Assumes: host logic and deserialiser run on i_ref_clk
// Notes: frame layout is marker, control block, status block, pattern
`timescale 1ns/100ps
`include "ltpc_defs.svh"
module ltpc_top #(
  parameter int TIMEOUT_CYCLES = `LTPC_TIMEOUT_CYCLES,
  parameter int FRAME_WORDS = `LTPC_FRAME_WORDS,
  parameter int LOCK_FRAMES = `LTPC_LOCK_FRAMES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_train_en_in,
  input wire logic i_train_restart_in,
  input wire logic i_rx_fir_done_in,
  input wire logic [10:0] i_pattern_seed_in,
  input wire ltpc_pkg::ltpc_ctl_t i_send_ctl,
  input wire ltpc_pkg::ltpc_stat_t i_send_stat,
  input wire logic [15:0] i_rx_data,
  input wire logic i_rx_valid,
  input wire logic i_an_enable,
  input wire logic i_an_bypass,
  input wire logic i_negotiation_good_check_state,
  output logic o_train_done_detect_out,
  output logic o_train_active_out,
  output logic o_train_timeout_fail_out,
  output logic o_train_frame_sync_out,
  output logic o_mission_mode,
  output ltpc_pkg::ltpc_ctl_t o_rcvd_ctl,
  output ltpc_pkg::ltpc_stat_t o_rcvd_stat,
  output logic o_rx_train_frame_start,
  output logic o_negotiation_good_check_pulse,
  output logic [15:0] o_tx_data,
  output logic o_tx_valid
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int FW = $clog2(FRAME_WORDS + 1);
  localparam int LW = $clog2(LOCK_FRAMES + 1);

  generate
    if (TIMEOUT_CYCLES < 1 || FRAME_WORDS < 4 || LOCK_FRAMES < 1) begin : g_bad
      $error("ltpc_top: unsupported parameter values");
    end
  endgenerate

  ltpc_pkg::ltpc_state_t state;
  ltpc_pkg::ltpc_state_t next_state;
  logic [TW-1:0] timer;
  logic [FW-1:0] tx_idx;
  logic [FW-1:0] rx_pos;
  logic [LW-1:0] good_frames;
  logic rx_lock;
  logic train_start;
  logic timed_out;
  logic st_train;
  logic rx_marker;
  logic good_check_seen;
  logic [10:0] pattern;
  ltpc_pkg::ltpc_ctl_t snap_ctl;
  ltpc_pkg::ltpc_stat_t snap_stat;

  assign st_train = (state == ltpc_pkg::LTPC_TRAIN);
  // a restart while enabled reloads state, timer, transmit framing and pattern seed, whatever the state
  assign train_start = i_train_en_in
    && (i_train_restart_in || state == ltpc_pkg::LTPC_OFF);
  assign timed_out = st_train && (timer == TW'(TIMEOUT_CYCLES - 1));
  assign rx_marker = i_rx_valid && (i_rx_data == `LTPC_MARKER);

  // training state
  always_comb begin
    next_state = state;
    if (!i_train_en_in) begin
      next_state = ltpc_pkg::LTPC_OFF;
    end else if (train_start) begin
      next_state = ltpc_pkg::LTPC_TRAIN;
    end else begin
      case (state)
        ltpc_pkg::LTPC_TRAIN: begin
          if (timed_out) begin
            next_state = ltpc_pkg::LTPC_FAIL;
          end else if (i_rx_fir_done_in && rx_lock) begin
            // the host only flags done once its FIR setup is finished
            next_state = ltpc_pkg::LTPC_SEND_DATA;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state <= ltpc_pkg::LTPC_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || train_start) begin
      timer <= '0;
    end else if (st_train) begin
      timer <= timer + TW'(1);
    end
  end

  // status flags straight from the state register
  assign o_train_active_out = st_train;
  assign o_train_done_detect_out
    = (state == ltpc_pkg::LTPC_SEND_DATA);
  assign o_train_timeout_fail_out = (state == ltpc_pkg::LTPC_FAIL);
  assign o_mission_mode = (state == ltpc_pkg::LTPC_OFF);
  // lock is only reported once training has started
  assign o_train_frame_sync_out = rx_lock
    && (state != ltpc_pkg::LTPC_OFF);

  // transmit framing
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || train_start) begin
      tx_idx <= '0;
    end else if (st_train) begin
      tx_idx <= (tx_idx == FW'(FRAME_WORDS - 1)) ? '0 : tx_idx + FW'(1);
    end
  end

  // fields are sampled once per frame, so the host must hold them a frame
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      snap_ctl <= '0;
      snap_stat <= '0;
    end else if (st_train && tx_idx == '0) begin
      snap_ctl <= i_send_ctl;
      snap_stat <= i_send_stat;
    end
  end

  ltpc_prbs u_prbs (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_load(train_start),
    .i_seed(i_pattern_seed_in),
    .i_step(st_train),
    .o_state(pattern)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_tx_data <= 16'h0000;
      o_tx_valid <= 1'b0;
    end else begin
      o_tx_valid <= st_train && !train_start;
      if (tx_idx == '0) begin
        o_tx_data <= `LTPC_MARKER;
      end else if (tx_idx == FW'(`LTPC_POS_CTL)) begin
        o_tx_data <= {8'h00, snap_ctl};
      end else if (tx_idx == FW'(`LTPC_POS_STAT)) begin
        o_tx_data <= {10'h000, snap_stat};
      end else begin
        o_tx_data <= {5'h00, pattern};
      end
    end
  end

  // receive framing; both directions share one clock, so no crossing
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rx_pos <= FW'(FRAME_WORDS - 1);
    end else if (rx_marker) begin
      rx_pos <= '0;
    end else if (i_rx_valid && rx_pos != FW'(FRAME_WORDS - 1)) begin
      rx_pos <= rx_pos + FW'(1);
    end
  end

  // a missing marker where one was due drops lock at once
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_train_en_in) begin
      good_frames <= '0;
      rx_lock <= 1'b0;
    end else if (rx_marker) begin
      if (rx_pos == FW'(FRAME_WORDS - 1) && good_frames != '0) begin
        if (good_frames == LW'(LOCK_FRAMES)) begin
          rx_lock <= 1'b1;
        end else begin
          good_frames <= good_frames + LW'(1);
        end
      end else begin
        good_frames <= LW'(1);
        rx_lock <= 1'b0;
      end
    end else if (i_rx_valid && rx_pos == FW'(FRAME_WORDS - 1)) begin
      good_frames <= '0;
      rx_lock <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rx_train_frame_start <= 1'b0;
    end else begin
      o_rx_train_frame_start <= rx_marker;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rcvd_ctl <= '0;
      o_rcvd_stat <= '0;
    end else if (i_rx_valid && !rx_marker) begin
      if (rx_pos == FW'(`LTPC_POS_CTL - 1)) begin
        o_rcvd_ctl <= i_rx_data[7:0];
      end
      if (rx_pos == FW'(`LTPC_POS_STAT - 1)) begin
        o_rcvd_stat <= i_rx_data[5:0];
      end
    end
  end

  // entry edge of the negotiation good-check state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      good_check_seen <= 1'b0;
      o_negotiation_good_check_pulse <= 1'b0;
    end else begin
      good_check_seen <= i_negotiation_good_check_state;
      o_negotiation_good_check_pulse <= i_negotiation_good_check_state
        && !good_check_seen && i_an_enable && !i_an_bypass;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  disabled_mission_a: assert property (
    !i_train_en_in |=> (o_mission_mode && !o_train_active_out))
    else $error("training active while disabled");

  restart_train_a: assert property (
    (i_train_en_in && i_train_restart_in) |=> (st_train && timer == '0))
    else $error("restart did not reload training");

  done_entry_a: assert property (
    (st_train && i_train_en_in && !i_train_restart_in && !timed_out
      && i_rx_fir_done_in && rx_lock) |=> o_train_done_detect_out)
    else $error("done detect missing after training success");

  active_level_a: assert property (
    (st_train && i_train_en_in && !timed_out
      && !(i_rx_fir_done_in && rx_lock))
      |=> (o_train_active_out && !o_train_done_detect_out))
    else $error("active output does not follow training");

  timeout_fail_a: assert property (
    (st_train && timer == TW'(TIMEOUT_CYCLES - 1) && i_train_en_in
      && !i_train_restart_in) |=> o_train_timeout_fail_out)
    else $error("timeout did not raise failure");

  sync_gate_a: assert property (
    o_train_frame_sync_out |-> (rx_lock && !o_mission_mode))
    else $error("frame lock shown outside training");

  ctl_capture_a: assert property (
    (rx_marker ##1 (i_rx_valid && !rx_marker))
      |=> (o_rcvd_ctl == $past(i_rx_data[7:0])))
    else $error("received control block not shown");

  stat_capture_a: assert property (
    (rx_marker ##1 (i_rx_valid && !rx_marker) ##1 (i_rx_valid && !rx_marker))
      |=> (o_rcvd_stat == $past(i_rx_data[5:0])))
    else $error("received status block not shown");

  tx_ctl_a: assert property (
    (st_train && tx_idx == '0 && !train_start) ##1 (st_train && !train_start)
      |=> (o_tx_data == {8'h00, $past(i_send_ctl, 2)}))
    else $error("control block not sent from host fields");

  tx_stat_a: assert property (
    (st_train && tx_idx == '0 && !train_start) ##1 (st_train && !train_start)
      ##1 (st_train && !train_start)
      |=> (o_tx_data == {10'h000, $past(i_send_stat, 3)}))
    else $error("status block not sent from host fields");

  sof_pulse_a: assert property (
    o_rx_train_frame_start |-> $past(rx_marker))
    else $error("frame start without a received marker");

  good_check_a: assert property (
    ($rose(i_negotiation_good_check_state) && i_an_enable && !i_an_bypass)
      |=> o_negotiation_good_check_pulse
        ##1 !o_negotiation_good_check_pulse)
    else $error("good check pulse wrong");

endmodule // ltpc_top

// ==== testbench/ltpc_partner.sv ====
// Purpose: remote link partner sending training frames
// Assumes: frame is marker, control word, status word, filler
// Notes: slow mode inserts an idle cycle after every word
`timescale 1ns/100ps
`include "ltpc_defs.svh"
module ltpc_partner #(
  parameter int FRAME_WORDS = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_on,
  input wire logic i_slow,
  input wire ltpc_pkg::ltpc_ctl_t i_ctl,
  input wire ltpc_pkg::ltpc_stat_t i_stat,
  output logic [15:0] o_rx_data,
  output logic o_rx_valid
);
  int pos = 0;
  logic gap = 1'b0;
  logic [11:0] fill = 12'h000;
  ltpc_pkg::ltpc_ctl_t ctl_hold;
  ltpc_pkg::ltpc_stat_t stat_hold;
  initial begin
    o_rx_data = 16'h0000;
    o_rx_valid = 1'b0;
  end
  always @(negedge i_ref_clk) begin
    fill <= fill + 12'h001;
    if ((!i_on && pos == 0) || (i_slow && !gap)) begin
      // idle line keeps moving so a stale word is never mistaken
      o_rx_valid <= 1'b0;
      o_rx_data <= {4'h0, fill};
      gap <= 1'b1;
    end else begin
      gap <= 1'b0;
      o_rx_valid <= 1'b1;
      pos <= (pos == FRAME_WORDS - 1) ? 0 : pos + 1;
      case (pos)
        0: begin
          o_rx_data <= `LTPC_MARKER;
          ctl_hold <= i_ctl;
          stat_hold <= i_stat;
        end
        1: o_rx_data <= {8'h00, ctl_hold};
        2: o_rx_data <= {10'h000, stat_hold};
        default: o_rx_data <= {4'h0, fill};
      endcase
    end
  end
endmodule // ltpc_partner

// ==== testbench/ltpc_top_bench.sv ====
// Purpose: self-checking bench of the link training port control
// Assumes: short timeout parameter keeps the run brief
// Notes: inputs change on the falling edge, outputs read there too
`timescale 1ns/100ps
`include "ltpc_defs.svh"
module ltpc_top_bench;
  localparam int TMO = 400;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, rs = 1'b0, fir = 1'b0;
  logic an_en = 1'b0, byp = 1'b0, gc = 1'b0, p_on = 1'b0, p_slow = 1'b0;
  logic [10:0] seed = 11'h5a5;
  ltpc_pkg::ltpc_ctl_t sctl = 8'h9b, pctl = 8'hc6, rctl;
  ltpc_pkg::ltpc_stat_t sstat = 6'h27, pstat = 6'h1d, rstat;
  logic [15:0] rxd, txd;
  logic rxv, done, act, fail, sync, miss, sof, gcp, txv;
  int mismatches = 0, checks = 0, cycles = 0;
  always #20 clk = ~clk;
  ltpc_top #(.TIMEOUT_CYCLES(TMO)) i_ltpc_top (
    .i_ref_clk(clk), .i_reset(rst), .i_train_en_in(en),
    .i_train_restart_in(rs), .i_rx_fir_done_in(fir),
    .i_pattern_seed_in(seed), .i_send_ctl(sctl), .i_send_stat(sstat),
    .i_rx_data(rxd), .i_rx_valid(rxv), .i_an_enable(an_en),
    .i_an_bypass(byp), .i_negotiation_good_check_state(gc),
    .o_train_done_detect_out(done), .o_train_active_out(act),
    .o_train_timeout_fail_out(fail), .o_train_frame_sync_out(sync),
    .o_mission_mode(miss), .o_rcvd_ctl(rctl), .o_rcvd_stat(rstat),
    .o_rx_train_frame_start(sof), .o_negotiation_good_check_pulse(gcp),
    .o_tx_data(txd), .o_tx_valid(txv));
  ltpc_partner i_ltpc_partner (.i_ref_clk(clk), .i_on(p_on),
    .i_slow(p_slow), .i_ctl(pctl), .i_stat(pstat),
    .o_rx_data(rxd), .o_rx_valid(rxv));
  task automatic summarize;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic to_marker;
    // the start edge also loads a marker while tx_valid is still low
    for (int i = 0; i < 40 && !(txv === 1'b1
        && txd === `LTPC_MARKER); i++) cyc(1);
  endtask
  task automatic t_tx;
    en = 1'b1;
    cyc(1);
    chk(act, 1'b1);
    chk(miss, 1'b0);
    to_marker();
    chk(txv, 1'b1);
    sctl = 8'h64; // mid-frame change waits for the next frame
    cyc(1);
    chk(txd, 16'h009b);
    cyc(1);
    chk(txd, 16'h0027);
    cyc(1);
    chk(txd, 16'h052b);
    to_marker();
    cyc(1);
    chk(txd, 16'h0064);
  endtask
  task automatic t_rx;
    int n;
    logic prev;
    n = 0;
    prev = 1'b0;
    rs = 1'b1;
    cyc(1);
    rs = 1'b0;
    fir = 1'b1;
    p_on = 1'b1;
    p_slow = 1'b1;
    for (int i = 0; i < 300 && sync !== 1'b1; i++) begin
      cyc(1);
      if (sof === 1'b1) n++;
      chk(prev & sof, 1'b0);
      chk(done, 1'b0);
      prev = sof;
    end
    chk(n, `LTPC_LOCK_FRAMES + 1);
    chk(rctl, 8'hc6);
    chk(rstat, 6'h1d);
    cyc(3);
    chk(done, 1'b1);
    chk(act, 1'b0);
    // back-to-back words reach the capture path without idle gaps
    pctl = 8'h3a;
    pstat = 6'h32;
    p_slow = 1'b0;
    cyc(40);
    chk(rctl, 8'h3a);
    chk(rstat, 6'h32);
  endtask
  task automatic t_fail;
    int n;
    n = 0;
    rs = 1'b1;
    cyc(1);
    rs = 1'b0;
    fir = 1'b0;
    p_on = 1'b0;
    chk(act, 1'b1);
    chk(done, 1'b0);
    while (n < TMO + 10 && fail !== 1'b1) begin
      cyc(1);
      n++;
    end
    chk(n >= TMO - 3 && n <= TMO + 2, 1'b1);
    chk(act, 1'b0);
    en = 1'b0;
    cyc(2);
    chk({miss, fail, sync, txv}, 4'h8);
  endtask
  task automatic t_an(input logic b, input int exp);
    int n;
    n = 0;
    an_en = 1'b1;
    byp = b;
    gc = 1'b1;
    repeat (6) begin
      cyc(1);
      if (gcp === 1'b1) n++;
    end
    gc = 1'b0;
    cyc(1);
    chk(n, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    cyc(6);
    rst = 1'b0;
    chk({miss, act, txv}, 3'h4);
    t_tx();
    t_rx();
    t_fail();
    t_an(1'b0, 1);
    t_an(1'b1, 0);
    summarize();
  end
endmodule // ltpc_top_bench
